// ==== common/pssr_map.svh ====
`ifndef PSSR_MAP_SVH
`define PSSR_MAP_SVH
`define PSSR_ADDR_CAL_LO 8'h88
`define PSSR_ADDR_CAL_HI 8'ha1
`define PSSR_ADDR_ID 8'hd0
`define PSSR_ADDR_RESET 8'he0
`define PSSR_ADDR_STATUS 8'hf3
`define PSSR_ADDR_CTRL 8'hf4
`define PSSR_ADDR_CONFIG 8'hf5
`define PSSR_ADDR_P_HI 8'hf7
`define PSSR_ADDR_P_MID 8'hf8
`define PSSR_ADDR_P_LO 8'hf9
`define PSSR_ADDR_T_HI 8'hfa
`define PSSR_ADDR_T_MID 8'hfb
`define PSSR_ADDR_T_LO 8'hfc
`define PSSR_RESET_KEY 8'hb6
`define PSSR_SKIP_RAW 20'h80000
`define PSSR_RAW_RESET 20'h80000
`define PSSR_STAT_MEAS_BIT 3
`define PSSR_STAT_COPY_BIT 0
`define PSSR_CAL_COUNT 26
`define PSSR_MODE_SLEEP 2'h0
`define PSSR_DIR_BIT 7
`define PSSR_ADDR_UPPER 8'h80
`endif

// ==== common/pssr_pkg.sv ====
package pssr_pkg;
  // serial-side register access carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic start;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pssr_acc_t;
  typedef struct packed {
    logic [2:0] osrs_t;
    logic [2:0] osrs_p;
    logic [1:0] mode;
  } pssr_ctrl_t;
  typedef struct packed {
    logic [2:0] standby_duration;
    logic [2:0] filter;
    logic rsvd;
    logic three_wire_enable;
  } pssr_cfg_t;
  typedef enum logic [2:0] {PSSR_OVS_SKIP, PSSR_OVS_X1, PSSR_OVS_X2, PSSR_OVS_X4,
    PSSR_OVS_X8, PSSR_OVS_X16} pssr_ovs_t;
endpackage

// ==== rtl/pssr_ovs_decode.sv ====
`timescale 1ns/1ps
module pssr_ovs_decode (
  input wire logic [2:0] code,
  output pssr_pkg::pssr_ovs_t ratio
);
  import pssr_pkg::*;
  always_comb begin
    case (code)
      3'h0: ratio = PSSR_OVS_SKIP;
      3'h1: ratio = PSSR_OVS_X1;
      3'h2: ratio = PSSR_OVS_X2;
      3'h3: ratio = PSSR_OVS_X4;
      3'h4: ratio = PSSR_OVS_X8;
      default: ratio = PSSR_OVS_X16;
    endcase
  end
endmodule

// ==== rtl/pssr_raw_result.sv ====
`timescale 1ns/1ps
`include "pssr_map.svh"
module pssr_raw_result (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic skip,
  input wire logic [19:0] sample,
  output logic [19:0] raw
);
  import pssr_pkg::*;
  logic [19:0] next_raw;
  always_comb begin
    next_raw = raw;
    if (load) begin
      next_raw = skip ? `PSSR_SKIP_RAW : sample;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      raw <= `PSSR_RAW_RESET;
    end else begin
      raw <= next_raw;
    end
  end
endmodule

// ==== rtl/pssr_regbank.sv ====
`timescale 1ns/1ps
`include "pssr_map.svh"
module pssr_regbank #(
  parameter logic [7:0] IDENT_CODE = 8'h5a,
  parameter int CAL_COPY_CYCLES = 26
) (
  input wire logic CLK,
  input wire logic RST,
  input pssr_pkg::pssr_acc_t ACC,
  output logic [7:0] RDATA,
  input wire logic CONV_START,
  input wire logic CONV_DONE,
  input wire logic [19:0] PRESS_SAMPLE,
  input wire logic [19:0] TEMP_SAMPLE,
  input wire logic [7:0] CAL_NVM_DATA,
  output logic [4:0] CAL_NVM_ADDR,
  output pssr_pkg::pssr_ctrl_t CTRL,
  output pssr_pkg::pssr_cfg_t CFG,
  output logic THREE_WIRE,
  output pssr_pkg::pssr_ovs_t PRESS_RATIO,
  output pssr_pkg::pssr_ovs_t TEMP_RATIO,
  output logic MEASURING,
  output logic CAL_COPYING
);
  import pssr_pkg::*;
  // identification code value is arbitrary
  typedef enum {PSSR_ST_COPY, PSSR_ST_IDLE, PSSR_ST_PRECOPY, PSSR_ST_CONV} pssr_state_t;
  pssr_state_t state, next_state;
  pssr_ctrl_t ctrl, next_ctrl;
  pssr_cfg_t cfg, next_cfg;
  logic [7:0] cal [0:`PSSR_CAL_COUNT-1];
  logic [4:0] cal_idx, next_cal_idx;
  logic [7:0] addr_ptr, next_addr_ptr;
  logic [7:0] rdata, next_rdata;
  logic soft_rst;
  logic [19:0] raw_p, raw_t;
  logic load;
  logic [7:0] eff_addr;
  logic [7:0] rd_addr;

  assign soft_rst = ACC.wr && (eff_addr == `PSSR_ADDR_RESET) && (ACC.wdata == `PSSR_RESET_KEY);

  // serial address keeps seven bits; upper bit restored
  assign eff_addr = {1'b1, ACC.addr[6:0]} | `PSSR_ADDR_UPPER;

  assign load = (state == PSSR_ST_CONV) && CONV_DONE;

  pssr_ovs_decode u_dec_p (
    .code(ctrl.osrs_p),
    .ratio(PRESS_RATIO)
  );
  pssr_ovs_decode u_dec_t (
    .code(ctrl.osrs_t),
    .ratio(TEMP_RATIO)
  );

  pssr_raw_result u_raw_p (
    .clk(CLK),
    .rst(RST | soft_rst),
    .load(load),
    .skip(ctrl.osrs_p == 3'h0),
    .sample(PRESS_SAMPLE),
    .raw(raw_p)
  );
  pssr_raw_result u_raw_t (
    .clk(CLK),
    .rst(RST | soft_rst),
    .load(load),
    .skip(ctrl.osrs_t == 3'h0),
    .sample(TEMP_SAMPLE),
    .raw(raw_t)
  );

  // copy at reset and before every conversion; flags
  always_comb begin
    next_state = state;
    next_cal_idx = cal_idx;
    case (state)
      PSSR_ST_COPY, PSSR_ST_PRECOPY: begin
        next_cal_idx = cal_idx + 5'h1;
        if (cal_idx == 5'(CAL_COPY_CYCLES - 1)) begin
          next_cal_idx = 5'h0;
          next_state = (state == PSSR_ST_COPY) ? PSSR_ST_IDLE : PSSR_ST_CONV;
        end
      end
      PSSR_ST_IDLE: begin
        if (CONV_START) begin
          next_state = PSSR_ST_PRECOPY;
        end
      end
      PSSR_ST_CONV: begin
        if (CONV_DONE) begin
          next_state = PSSR_ST_IDLE;
        end
      end
      default: next_state = PSSR_ST_COPY;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST || soft_rst) begin
      state <= PSSR_ST_COPY;
      cal_idx <= 5'h0;
    end else begin
      state <= next_state;
      cal_idx <= next_cal_idx;
    end
  end

  always_ff @(posedge CLK) begin
    if (state == PSSR_ST_COPY || state == PSSR_ST_PRECOPY) begin
      cal[cal_idx] <= CAL_NVM_DATA;
    end
  end

  assign CAL_NVM_ADDR = cal_idx;
  assign MEASURING = (state == PSSR_ST_PRECOPY) || (state == PSSR_ST_CONV);
  assign CAL_COPYING = (state == PSSR_ST_COPY) || (state == PSSR_ST_PRECOPY);

  // control writes; config only in sleep
  always_comb begin
    next_ctrl = ctrl;
    next_cfg = cfg;
    if (ACC.wr && eff_addr == `PSSR_ADDR_CTRL) begin
      next_ctrl = ACC.wdata;
    end
    if (ACC.wr && eff_addr == `PSSR_ADDR_CONFIG && ctrl.mode == `PSSR_MODE_SLEEP) begin
      next_cfg = ACC.wdata;
      next_cfg.rsvd = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || soft_rst) begin
      ctrl <= '0;
      cfg <= '0;
    end else begin
      ctrl <= next_ctrl;
      cfg <= next_cfg;
    end
  end

  assign rd_addr = ACC.start ? eff_addr : addr_ptr;
  always_comb begin
    next_addr_ptr = addr_ptr;
    next_rdata = rdata;
    if (ACC.rd) begin
      next_addr_ptr = rd_addr + 8'h1;
      case (rd_addr)
        `PSSR_ADDR_ID: next_rdata = IDENT_CODE;
        `PSSR_ADDR_RESET: next_rdata = 8'h00;
        `PSSR_ADDR_STATUS: begin
          next_rdata = 8'h00;
          next_rdata[`PSSR_STAT_MEAS_BIT] = MEASURING;
          next_rdata[`PSSR_STAT_COPY_BIT] = CAL_COPYING;
        end
        `PSSR_ADDR_CTRL: next_rdata = ctrl;
        `PSSR_ADDR_CONFIG: next_rdata = cfg;
        `PSSR_ADDR_P_HI: next_rdata = raw_p[19:12];
        `PSSR_ADDR_P_MID: next_rdata = raw_p[11:4];
        `PSSR_ADDR_P_LO: next_rdata = {raw_p[3:0], 4'h0};
        `PSSR_ADDR_T_HI: next_rdata = raw_t[19:12];
        `PSSR_ADDR_T_MID: next_rdata = raw_t[11:4];
        `PSSR_ADDR_T_LO: next_rdata = {raw_t[3:0], 4'h0};
        default: begin
          next_rdata = 8'h00;
          if (rd_addr >= `PSSR_ADDR_CAL_LO && rd_addr <= `PSSR_ADDR_CAL_HI) begin
            next_rdata = cal[5'(rd_addr - `PSSR_ADDR_CAL_LO)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_ptr <= 8'h00;
      rdata <= 8'h00;
    end else begin
      addr_ptr <= next_addr_ptr;
      rdata <= next_rdata;
    end
  end

  assign RDATA = rdata;
  assign CTRL = ctrl;
  assign CFG = cfg;
  assign THREE_WIRE = cfg.three_wire_enable;

  a_cfg_sleep_only: assert property (@(posedge CLK) disable iff (RST)
    (ACC.wr && eff_addr == `PSSR_ADDR_CONFIG && ctrl.mode != `PSSR_MODE_SLEEP && !soft_rst)
    |=> $stable(cfg)) else $error("config changed outside sleep");
  a_soft_reset_key: assert property (@(posedge CLK) disable iff (RST)
    soft_rst |=> (ctrl == '0 && cfg == '0 && CAL_COPYING)) else $error("soft reset incomplete");
  a_reset_read_zero: assert property (@(posedge CLK) disable iff (RST)
    (ACC.rd && rd_addr == `PSSR_ADDR_RESET) |=> RDATA == 8'h00) else $error("reset word read nonzero");
  a_id_read: assert property (@(posedge CLK) disable iff (RST)
    (ACC.rd && rd_addr == `PSSR_ADDR_ID) |=> RDATA == IDENT_CODE) else $error("bad identity");
  a_meas_clear: assert property (@(posedge CLK) disable iff (RST || soft_rst)
    load |=> !MEASURING) else $error("measuring stuck after load");
  a_copy_before_conv: assert property (@(posedge CLK) disable iff (RST || soft_rst)
    (state == PSSR_ST_IDLE && CONV_START) |=> CAL_COPYING && MEASURING) else $error("no copy before conversion");
  a_skip_forced: assert property (@(posedge CLK) disable iff (RST || soft_rst)
    (load && ctrl.osrs_p == 3'h0) |=> raw_p == `PSSR_SKIP_RAW) else $error("skip not forced");
  a_xlsb_low_zero: assert property (@(posedge CLK) disable iff (RST)
    (ACC.rd && (rd_addr == `PSSR_ADDR_P_LO || rd_addr == `PSSR_ADDR_T_LO)) |=> RDATA[3:0] == 4'h0)
    else $error("low nibble nonzero");
  a_burst_incr: assert property (@(posedge CLK) disable iff (RST)
    ACC.rd |=> addr_ptr == $past(rd_addr) + 8'h1) else $error("pointer not incremented");

  logic [5:0] copy_len, next_copy_len;
  always_comb begin
    next_copy_len = 6'h0;
    if (CAL_COPYING) begin
      next_copy_len = copy_len + 6'h1;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST || soft_rst) begin
      copy_len <= 6'h0;
    end else begin
      copy_len <= next_copy_len;
    end
  end

  a_copy_bounded: assert property (@(posedge CLK) disable iff (RST)
    copy_len <= 6'(CAL_COPY_CYCLES))
    else $error("calibration copy overran");
  a_copy_ends: assert property (@(posedge CLK) disable iff (RST || soft_rst)
    (CAL_COPYING && cal_idx == 5'(CAL_COPY_CYCLES - 1)) |=> !CAL_COPYING)
    else $error("calibration copy did not end");
  a_ctrl_fields: assert property (@(posedge CLK) disable iff (RST)
    (ACC.wr && eff_addr == `PSSR_ADDR_CTRL) |=> {ctrl.osrs_t, ctrl.osrs_p, ctrl.mode} == $past(ACC.wdata))
    else $error("control fields misplaced");
  a_cfg_fields: assert property (@(posedge CLK) disable iff (RST)
    (ACC.wr && eff_addr == `PSSR_ADDR_CONFIG && ctrl.mode == `PSSR_MODE_SLEEP)
    |=> {cfg.standby_duration, cfg.filter} == $past(ACC.wdata[7:2]))
    else $error("config fields misplaced");
  a_three_wire_set: assert property (@(posedge CLK) disable iff (RST)
    (ACC.wr && eff_addr == `PSSR_ADDR_CONFIG && ctrl.mode == `PSSR_MODE_SLEEP)
    |=> THREE_WIRE == $past(ACC.wdata[0]))
    else $error("three-wire select wrong");
  a_cfg_rsvd_zero: assert property (@(posedge CLK) disable iff (RST)
    !cfg.rsvd)
    else $error("config reserved bit set");
  a_press_x16: assert property (@(posedge CLK) disable iff (RST)
    (ctrl.osrs_p >= 3'h5) |-> PRESS_RATIO == PSSR_OVS_X16)
    else $error("pressure ratio not x16");
  a_temp_x16: assert property (@(posedge CLK) disable iff (RST)
    (ctrl.osrs_t >= 3'h5) |-> TEMP_RATIO == PSSR_OVS_X16)
    else $error("temperature ratio not x16");
  a_press_skip_code: assert property (@(posedge CLK) disable iff (RST)
    (ctrl.osrs_p == 3'h0) |-> PRESS_RATIO == PSSR_OVS_SKIP)
    else $error("pressure skip not decoded");
  a_temp_skip_forced: assert property (@(posedge CLK) disable iff (RST || soft_rst)
    (load && ctrl.osrs_t == 3'h0) |=> raw_t == `PSSR_SKIP_RAW)
    else $error("temperature skip not forced");
  a_press_loaded: assert property (@(posedge CLK) disable iff (RST || soft_rst)
    (load && ctrl.osrs_p != 3'h0) |=> raw_p == $past(PRESS_SAMPLE))
    else $error("pressure result not loaded");
  a_temp_loaded: assert property (@(posedge CLK) disable iff (RST || soft_rst)
    (load && ctrl.osrs_t != 3'h0) |=> raw_t == $past(TEMP_SAMPLE))
    else $error("temperature result not loaded");
  a_raw_held: assert property (@(posedge CLK) disable iff (RST || soft_rst)
    !load |=> ($stable(raw_p) && $stable(raw_t)))
    else $error("result changed outside load");
  a_press_high_read: assert property (@(posedge CLK) disable iff (RST)
    (ACC.rd && rd_addr == `PSSR_ADDR_P_HI) |=> RDATA == $past(raw_p[19:12]))
    else $error("pressure high byte wrong");
  a_press_mid_read: assert property (@(posedge CLK) disable iff (RST)
    (ACC.rd && rd_addr == `PSSR_ADDR_P_MID) |=> RDATA == $past(raw_p[11:4]))
    else $error("pressure mid byte wrong");
  a_temp_high_read: assert property (@(posedge CLK) disable iff (RST)
    (ACC.rd && rd_addr == `PSSR_ADDR_T_HI) |=> RDATA == $past(raw_t[19:12]))
    else $error("temperature high byte wrong");
  a_temp_low_read: assert property (@(posedge CLK) disable iff (RST)
    (ACC.rd && rd_addr == `PSSR_ADDR_T_LO) |=> RDATA[7:4] == $past(raw_t[3:0]))
    else $error("temperature low nibble wrong");
  a_status_bits: assert property (@(posedge CLK) disable iff (RST)
    (ACC.rd && rd_addr == `PSSR_ADDR_STATUS)
    |=> RDATA[`PSSR_STAT_MEAS_BIT] == $past(MEASURING) && RDATA[`PSSR_STAT_COPY_BIT] == $past(CAL_COPYING))
    else $error("status bits wrong");
  a_bad_key_ignored: assert property (@(posedge CLK) disable iff (RST)
    (ACC.wr && eff_addr == `PSSR_ADDR_RESET && ACC.wdata != `PSSR_RESET_KEY)
    |=> ($stable(ctrl) && $stable(cfg)))
    else $error("non-key reset write had effect");
  a_meas_start: assert property (@(posedge CLK) disable iff (RST || soft_rst)
    $rose(MEASURING) |-> $past(CONV_START))
    else $error("measuring set without request");
  a_rdata_hold: assert property (@(posedge CLK) disable iff (RST)
    !ACC.rd |=> $stable(RDATA))
    else $error("read byte changed without read");
  a_cal_first_read: assert property (@(posedge CLK) disable iff (RST)
    (ACC.rd && rd_addr == `PSSR_ADDR_CAL_LO) |=> RDATA == $past(cal[0]))
    else $error("calibration byte wrong");
endmodule

// ==== bench/pssr_nvm_model.sv ====
`timescale 1ns/1ps
module pssr_nvm_model (
  input wire logic [4:0] addr,
  output logic [7:0] data
);
  assign data = {3'h5, addr};
endmodule

// ==== bench/tb_pressure_sensor_register_map.sv ====
`timescale 1ns/1ps
module tb_pressure_sensor_register_map;
  import pssr_pkg::*;
  logic clk, rst, conv_start, conv_done;
  pssr_acc_t acc;
  logic [7:0] rdata, nvm_data;
  logic [4:0] nvm_addr;
  logic [19:0] press_sample, temp_sample;
  pssr_ctrl_t ctrl;
  pssr_cfg_t cfg;
  logic three_wire, measuring, cal_copying;
  pssr_ovs_t press_ratio, temp_ratio;
  logic [7:0] burst [12] = '{8'h80, 8'h00, 8'h00, 8'hab, 8'hcd, 8'he0, 8'h12, 8'h34, 8'h50, 8'h80, 8'h00, 8'h00};
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  // identity value 8'h3c is arbitrary
  pssr_regbank #(.IDENT_CODE(8'h3c)) u_pssr_regbank (.CLK(clk), .RST(rst), .ACC(acc), .RDATA(rdata),
    .CONV_START(conv_start), .CONV_DONE(conv_done), .PRESS_SAMPLE(press_sample),
    .TEMP_SAMPLE(temp_sample), .CAL_NVM_DATA(nvm_data), .CAL_NVM_ADDR(nvm_addr), .CTRL(ctrl),
    .CFG(cfg), .THREE_WIRE(three_wire), .PRESS_RATIO(press_ratio), .TEMP_RATIO(temp_ratio),
    .MEASURING(measuring), .CAL_COPYING(cal_copying));
  pssr_nvm_model u_pssr_nvm_model (.addr(nvm_addr), .data(nvm_data));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task conclude;
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    acc <= {1'b1, 1'b0, 1'b0, a, d};
    @(posedge clk);
    acc <= '0;
  endtask
  task rd(input logic [7:0] a, input logic st, input logic [7:0] exp);
    @(posedge clk);
    acc <= {1'b0, 1'b1, st, a, 8'h00};
    @(posedge clk);
    acc <= '0;
    #1 check(rdata, exp);
  endtask
  // wait for the calibration copy to finish, bounded
  task settle;
    #1;
    for (int i = 0; i < 100 && cal_copying !== 1'b0; i++) @(posedge clk);
    #1 check(cal_copying, 1'b0);
  endtask
  function automatic pssr_ovs_t ovs(input logic [2:0] c);
    return (c >= 3'h5) ? PSSR_OVS_X16 : pssr_ovs_t'(c);
  endfunction
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    rst = 1'b1;
    acc = '0;
    conv_start = 1'b0;
    conv_done = 1'b0;
    press_sample = 20'h12345;
    temp_sample = 20'habcde;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    settle();
    rd(8'hd0, 1'b1, 8'h3c);
    rd(8'h50, 1'b1, 8'h3c);
    rd(8'h88, 1'b1, 8'ha0);
    rd(8'ha1, 1'b1, 8'hb9);
    rd(8'hf7, 1'b1, 8'h80);
    rd(8'hfa, 1'b1, 8'h80);
    rd(8'hf3, 1'b1, 8'h00);
    wr(8'he0, 8'h55);
    rd(8'he0, 1'b1, 8'h00);
    wr(8'hf5, 8'hff);
    rd(8'hf5, 1'b1, 8'hfd);
    check(cfg, 8'hfd);
    check(three_wire, 1'b1);
    wr(8'hf4, 8'h27);
    wr(8'h75, 8'h00);
    rd(8'hf4, 1'b1, 8'h27);
    check(ctrl, 8'h27);
    rd(8'hf5, 1'b1, 8'hfd);
    wr(8'he0, 8'h11);
    rd(8'hf4, 1'b1, 8'h27);
    for (int c = 0; c < 8; c++) begin
      wr(8'hf4, {c[2:0], c[2:0], 2'b00});
      #1 check(press_ratio, ovs(c[2:0]));
      check(temp_ratio, ovs(c[2:0]));
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'hf4, (k == 0) ? 8'h20 : 8'h04);
      @(posedge clk) conv_start <= 1'b1;
      @(posedge clk) conv_start <= 1'b0;
      #1 check(cal_copying & measuring, 1'b1);
      settle();
      @(posedge clk) conv_done <= 1'b1;
      @(posedge clk) conv_done <= 1'b0;
      #1 check(measuring, 1'b0);
      for (int i = 0; i < 6; i++) rd(8'hf7, i == 0, burst[6 * k + i]);
    end
    wr(8'he0, 8'hb6);
    settle();
    rd(8'hf4, 1'b1, 8'h00);
    rd(8'hf7, 1'b1, 8'h80);
    conclude();
  end
endmodule
